//--- rtl/psr_pkg.sv
// Constants shared by the PLL status readback block
package psr_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int PSR_ADDR_W = 10;
  localparam int PSR_DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [PSR_ADDR_W-1:0] PSR_PLL_STATUS_OFS = 10'h01f;

  // ----------------------------------------------------------------
  // Field positions inside the status register
  // ----------------------------------------------------------------
  localparam int PSR_BIT_LOCK = 0;
  localparam int PSR_BIT_PRI_ABOVE = 1;
  localparam int PSR_BIT_SEC_ABOVE = 2;
  localparam int PSR_BIT_EXT_ABOVE = 3;
  localparam int PSR_BIT_SEC_SEL = 4;
  localparam int PSR_BIT_HOLDOVER = 5;
  localparam int PSR_NUM_STATUS = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PSR_DATA_W-1:0] PSR_RDATA_RST = 8'h00;
  localparam logic [PSR_NUM_STATUS-1:0] PSR_STATUS_RST = 6'h00;
  localparam logic [PSR_DATA_W-1:0] PSR_UNMAPPED_VAL = 8'h00;

  // ----------------------------------------------------------------
  // Timing: synchroniser depth in clock cycles
  // ----------------------------------------------------------------
  localparam int PSR_SYNC_STAGES = 3;

endpackage

//--- rtl/psr_sync_filt.sv
// Three-stage synchroniser with agreement filter, one lane per bit
`timescale 1ns/100ps

module psr_sync_filt #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Asynchronous levels in, filtered levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] filtOut_q
);

  // ----------------------------------------------------------------
  // Per-bit lanes
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_lane
      logic meta_q;
      logic sync2_q;
      logic sync3_q;
      logic filt_d;

      // Filter only looks at stages two and three, never the first
      assign filt_d = (sync2_q == sync3_q) ? sync3_q : filtOut_q[gi];

      // Chain plus held value; a lone glitch cannot reach the output
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_q <= RST_VAL[gi];
          sync2_q <= RST_VAL[gi];
          sync3_q <= RST_VAL[gi];
          filtOut_q[gi] <= RST_VAL[gi];
        end
        else
        begin
          meta_q <= asyncIn[gi];
          sync2_q <= meta_q;
          sync3_q <= sync2_q;
          filtOut_q[gi] <= filt_d;
        end
      end
    end
  endgenerate

endmodule

//--- rtl/psr_status_reg.sv
// Read-only PLL status register with its register read port
//
// Function
// - Bit 5 reads 1 while the part is in holdover, else 0.
// - Holdover bit follows the real holdover state, not the enable setting.
// - Bit 4 reads 1 when second reference feeds the PLL, else 0.
// - Bit 3 reads 1 when external clock is above its monitor threshold.
// - Bit 2 reads 1 when second reference is above selected threshold.
// - Bit 1 reads 1 when first reference is above selected threshold.
// - Bit 0 shows the digital lock detector: 1 locked, 0 not.
`timescale 1ns/100ps

module psr_status_reg (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Status sources from other blocks, other clock domains
  input wire logic holdoverActive,
  input wire logic secondaryRefSelected,
  input wire logic extClkAboveThresh,
  input wire logic secondaryAboveThresh,
  input wire logic primaryAboveThresh,
  input wire logic digitalLock,
  // Register access port from the serial control port
  input wire logic [psr_pkg::PSR_ADDR_W-1:0] regAddr,
  input wire logic regRd,
  input wire logic regWr,
  input wire logic [psr_pkg::PSR_DATA_W-1:0] regWdata,
  output logic [psr_pkg::PSR_DATA_W-1:0] regRdata_q,
  output logic regRdValid_q
);
  import psr_pkg::*;

  // ----------------------------------------------------------------
  // Status capture
  // ----------------------------------------------------------------
  logic [PSR_NUM_STATUS-1:0] rawStatus;
  logic [PSR_NUM_STATUS-1:0] statusVec;

  // Gather the sources in register bit order
  assign rawStatus[PSR_BIT_HOLDOVER] = holdoverActive;
  assign rawStatus[PSR_BIT_SEC_SEL] = secondaryRefSelected;
  assign rawStatus[PSR_BIT_EXT_ABOVE] = extClkAboveThresh;
  assign rawStatus[PSR_BIT_SEC_ABOVE] = secondaryAboveThresh;
  assign rawStatus[PSR_BIT_PRI_ABOVE] = primaryAboveThresh;
  assign rawStatus[PSR_BIT_LOCK] = digitalLock;

  // Sources run on foreign clocks, so each passes the filter chain
  psr_sync_filt #(
    .WIDTH(PSR_NUM_STATUS),
    .RST_VAL(PSR_STATUS_RST)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .asyncIn(rawStatus),
    .filtOut_q(statusVec)
  );

  // ----------------------------------------------------------------
  // Address decode and read data
  // ----------------------------------------------------------------
  logic statusHit;
  logic [PSR_DATA_W-1:0] statusWord;
  logic [PSR_DATA_W-1:0] rdMux;
  logic [PSR_DATA_W-1:0] regRdata_d;
  logic wrUnused;

  // Upper two bits are reserved and read as zero
  assign statusWord = {{(PSR_DATA_W-PSR_NUM_STATUS){1'b0}}, statusVec};
  assign statusHit = (regAddr == PSR_PLL_STATUS_OFS);
  assign rdMux = statusHit ? statusWord : PSR_UNMAPPED_VAL;
  // Read returns a snapshot; capture changes nothing upstream
  assign regRdata_d = regRd ? rdMux : regRdata_q;
  // Writes land nowhere: the register has no storage to change
  assign wrUnused = regWr & (|regWdata);

  // Read answer one cycle after the strobe, held until the next read
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regRdata_q <= PSR_RDATA_RST;
      regRdValid_q <= 1'b0;
    end
    else
    begin
      regRdata_q <= regRdata_d;
      regRdValid_q <= regRd;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_hold_read;
    @(posedge mclk) disable iff (!rst_b)
    (regRd && statusHit) |=>
      (regRdata_q[PSR_BIT_HOLDOVER] == $past(statusVec[PSR_BIT_HOLDOVER]));
  endproperty
  a_hold_read: assert property (p_hold_read)
    else $error("holdover bit read back wrong");

  property p_hold_track;
    @(posedge mclk) disable iff (!rst_b)
    (holdoverActive[*4]) |=> statusVec[PSR_BIT_HOLDOVER];
  endproperty
  a_hold_track: assert property (p_hold_track)
    else $error("holdover state not reflected after three stages");

  property p_hold_clear;
    @(posedge mclk) disable iff (!rst_b)
    (!holdoverActive[*4]) |=> !statusVec[PSR_BIT_HOLDOVER];
  endproperty
  a_hold_clear: assert property (p_hold_clear)
    else $error("holdover bit stuck high after leaving holdover");

  property p_sel_read;
    @(posedge mclk) disable iff (!rst_b)
    (regRd && statusHit) |=>
      (regRdata_q[PSR_BIT_SEC_SEL] == $past(statusVec[PSR_BIT_SEC_SEL]));
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("reference select bit read back wrong");

  property p_ext_track;
    @(posedge mclk) disable iff (!rst_b)
    (extClkAboveThresh[*4] ##1 (regRd && statusHit)) |=>
      regRdata_q[PSR_BIT_EXT_ABOVE];
  endproperty
  a_ext_track: assert property (p_ext_track)
    else $error("external clock monitor bit not reported");

  property p_sec_read;
    @(posedge mclk) disable iff (!rst_b)
    (regRd && statusHit) |=>
      (regRdata_q[PSR_BIT_SEC_ABOVE] == $past(statusVec[PSR_BIT_SEC_ABOVE]));
  endproperty
  a_sec_read: assert property (p_sec_read)
    else $error("second reference monitor bit read back wrong");

  property p_pri_track;
    @(posedge mclk) disable iff (!rst_b)
    (!primaryAboveThresh[*4] ##1 (regRd && statusHit)) |=>
      !regRdata_q[PSR_BIT_PRI_ABOVE];
  endproperty
  a_pri_track: assert property (p_pri_track)
    else $error("first reference monitor bit reported high when low");

  property p_lock_track;
    @(posedge mclk) disable iff (!rst_b)
    (digitalLock[*4] ##1 (regRd && statusHit)) |=>
      regRdata_q[PSR_BIT_LOCK];
  endproperty
  a_lock_track: assert property (p_lock_track)
    else $error("lock detect not reported while locked");

  property p_no_side_effect;
    @(posedge mclk) disable iff (!rst_b)
    (!regRd) |=> ($stable(regRdata_q) && !regRdValid_q);
  endproperty
  a_no_side_effect: assert property (p_no_side_effect)
    else $error("read data moved without a read strobe");

  // Stability is judged at the second strobe, the edge that captures it
  property p_reread_same;
    @(posedge mclk) disable iff (!rst_b)
    (regRd && statusHit) ##1 (regRd && statusHit && $stable(statusVec))
      |=> (regRdata_q == $past(regRdata_q));
  endproperty
  a_reread_same: assert property (p_reread_same)
    else $error("second read differs although status was stable");

  property p_reserved_zero;
    @(posedge mclk) disable iff (!rst_b)
    regRdValid_q |-> (regRdata_q[PSR_DATA_W-1:PSR_NUM_STATUS] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_unmapped;
    @(posedge mclk) disable iff (!rst_b)
    (regRd && !statusHit) |=> (regRdata_q == PSR_UNMAPPED_VAL);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");

  // Every strobe is answered exactly one cycle later
  property p_valid_pulse;
    @(posedge mclk) disable iff (!rst_b)
    regRd |=> regRdValid_q;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("read strobe not answered one cycle later");

  // A write with data must leave the read side untouched
  property p_write_ignored;
    @(posedge mclk) disable iff (!rst_b)
    (wrUnused && !regRd) |=> ($stable(regRdata_q) && !regRdValid_q);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write strobe disturbed the read port");

  property p_sel_track;
    @(posedge mclk) disable iff (!rst_b)
    (secondaryRefSelected[*4] ##1 (regRd && statusHit)) |=>
      regRdata_q[PSR_BIT_SEC_SEL];
  endproperty
  a_sel_track: assert property (p_sel_track)
    else $error("second reference selection not reported");

  property p_ext_clear;
    @(posedge mclk) disable iff (!rst_b)
    (!extClkAboveThresh[*4] ##1 (regRd && statusHit)) |=>
      !regRdata_q[PSR_BIT_EXT_ABOVE];
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("external clock monitor bit high when below threshold");

  property p_sec_track;
    @(posedge mclk) disable iff (!rst_b)
    (secondaryAboveThresh[*4] ##1 (regRd && statusHit)) |=>
      regRdata_q[PSR_BIT_SEC_ABOVE];
  endproperty
  a_sec_track: assert property (p_sec_track)
    else $error("second reference monitor bit not reported");

  property p_pri_set;
    @(posedge mclk) disable iff (!rst_b)
    (primaryAboveThresh[*4] ##1 (regRd && statusHit)) |=>
      regRdata_q[PSR_BIT_PRI_ABOVE];
  endproperty
  a_pri_set: assert property (p_pri_set)
    else $error("first reference monitor bit not reported");

  property p_lock_clear;
    @(posedge mclk) disable iff (!rst_b)
    (!digitalLock[*4] ##1 (regRd && statusHit)) |=>
      !regRdata_q[PSR_BIT_LOCK];
  endproperty
  a_lock_clear: assert property (p_lock_clear)
    else $error("lock reported while lock detect is low");

endmodule

//--- tb/psr_status_reg_bench.sv
// Self-checking bench for the PLL status readback register
`timescale 1ns/100ps

module psr_status_reg_bench;
  import psr_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus, observed outputs and bookkeeping
  // ----------------------------------------------------------------
  logic mclk;
  logic rst_b;
  logic [PSR_NUM_STATUS-1:0] stat;
  logic [PSR_ADDR_W-1:0] regAddr;
  logic regRd;
  logic regWr;
  logic [PSR_DATA_W-1:0] regWdata;
  logic [PSR_DATA_W-1:0] regRdata_q;
  logic regRdValid_q;
  logic [PSR_DATA_W-1:0] expv;
  int errorCnt = 0;
  int samplesChecked = 0;
  int cycCnt = 0;

  // Device under test, status lanes taken from one vector
  psr_status_reg uut (
    .mclk(mclk),
    .rst_b(rst_b),
    .holdoverActive(stat[PSR_BIT_HOLDOVER]),
    .secondaryRefSelected(stat[PSR_BIT_SEC_SEL]),
    .extClkAboveThresh(stat[PSR_BIT_EXT_ABOVE]),
    .secondaryAboveThresh(stat[PSR_BIT_SEC_ABOVE]),
    .primaryAboveThresh(stat[PSR_BIT_PRI_ABOVE]),
    .digitalLock(stat[PSR_BIT_LOCK]),
    .regAddr(regAddr),
    .regRd(regRd),
    .regWr(regWr),
    .regWdata(regWdata),
    .regRdata_q(regRdata_q),
    .regRdValid_q(regRdValid_q)
  );

  // 40 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run, also reached by the hang guard
  task automatic final_report;
    begin
      $display("Checks made %0d, mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Compare and count
  task automatic chk(input string nm, input logic [PSR_DATA_W-1:0] seen,
                     input logic [PSR_DATA_W-1:0] exp);
    begin
      samplesChecked++;
      if (seen !== exp)
      begin
        errorCnt++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // Set status lanes, then let the filter settle for four edges
  task automatic setStat(input logic [PSR_NUM_STATUS-1:0] v);
    begin
      @(negedge mclk);
      stat = v;
      repeat (4) @(negedge mclk);
    end
  endtask

  // One read: valid one cycle later, data held after valid drops
  task automatic rd(input logic [PSR_ADDR_W-1:0] a,
                    input logic [PSR_DATA_W-1:0] e);
    begin
      @(negedge mclk);
      regAddr = a;
      regRd = 1'b1;
      @(negedge mclk);
      regRd = 1'b0;
      chk("valid", {7'h00, regRdValid_q}, 8'h01);
      chk("rdata", regRdata_q, e);
      @(negedge mclk);
      chk("valid off", {7'h00, regRdValid_q}, 8'h00);
      chk("rdata hold", regRdata_q, e);
    end
  endtask

  // Ignored write strobe
  task automatic wr(input logic [PSR_ADDR_W-1:0] a,
                    input logic [PSR_DATA_W-1:0] d);
    begin
      @(negedge mclk);
      regAddr = a;
      regWdata = d;
      regWr = 1'b1;
      @(negedge mclk);
      regWr = 1'b0;
    end
  endtask

  // Back to back: status read, then a second read on the next edge
  task automatic rd2(input logic [PSR_ADDR_W-1:0] a2,
                     input logic [PSR_DATA_W-1:0] e,
                     input logic [PSR_DATA_W-1:0] e2);
    begin
      @(negedge mclk);
      regAddr = PSR_PLL_STATUS_OFS;
      regRd = 1'b1;
      @(negedge mclk);
      regAddr = a2;
      chk("b2b first", regRdata_q, e);
      @(negedge mclk);
      regRd = 1'b0;
      chk("b2b valid", {7'h00, regRdValid_q}, 8'h01);
      chk("b2b second", regRdata_q, e2);
    end
  endtask

  // Hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge mclk)
  begin
    cycCnt++;
    if (cycCnt == 3000)
    begin
      errorCnt++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    stat = '0;
    regAddr = '0;
    regRd = 1'b0;
    regWr = 1'b0;
    regWdata = '0;
    rst_b = 1'b0;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    rd(PSR_PLL_STATUS_OFS, PSR_RDATA_RST);
    // Walking one and walking zero, so each lane is seen both ways
    for (int i = 0; i < PSR_NUM_STATUS; i++)
    begin
      expv = 8'h01 << i;
      setStat(expv[PSR_NUM_STATUS-1:0]);
      rd(PSR_PLL_STATUS_OFS, expv);
      setStat(~expv[PSR_NUM_STATUS-1:0]);
      rd(PSR_PLL_STATUS_OFS, {2'h0, ~expv[5:0]});
    end
    // Writes must leave the register alone, reads must not clear it
    setStat(6'h3f);
    rd(PSR_PLL_STATUS_OFS, 8'h3f);
    wr(PSR_PLL_STATUS_OFS, 8'h00);
    rd(PSR_PLL_STATUS_OFS, 8'h3f);
    setStat(6'h2a);
    wr(PSR_PLL_STATUS_OFS, 8'hff);
    rd(PSR_PLL_STATUS_OFS, 8'h2a);
    rd(PSR_PLL_STATUS_OFS, 8'h2a);
    // Neighbour and aliased addresses read as unmapped, then back-to-back reads
    rd(10'h01e, PSR_UNMAPPED_VAL);
    rd(10'h21f, PSR_UNMAPPED_VAL);
    rd2(PSR_PLL_STATUS_OFS, 8'h2a, 8'h2a);
    rd2(10'h000, 8'h2a, PSR_UNMAPPED_VAL);
    // Live value after a change
    setStat(6'h15);
    rd(PSR_PLL_STATUS_OFS, 8'h15);
    // Mid-run reset clears outputs and chain; status returns 4 edges later
    @(negedge mclk);
    rst_b = 1'b0;
    @(negedge mclk);
    chk("rst rdata", regRdata_q, PSR_RDATA_RST);
    chk("rst valid", {7'h00, regRdValid_q}, 8'h00);
    @(negedge mclk);
    rst_b = 1'b1;
    rd(PSR_PLL_STATUS_OFS, {2'h0, PSR_STATUS_RST});
    rd(PSR_PLL_STATUS_OFS, 8'h15);
    final_report();
  end

endmodule
